// file: core/cbp_ctrl.sv
// Block protocol controller of the tag: block numbers, replies, APDU framing.
`timescale 1ns/1ps
module cbp_ctrl #(
  parameter int RSP_MAX = cbp_pkg::RSP_MAX, // Response store size in bytes.
  parameter int CHUNK   = cbp_pkg::CHUNK    // Most INF bytes per sent I-block; the last may carry fewer.
) (
  input  wire logic        i_clk,       // Core clock, 20 MHz.
  input  wire logic        i_rst,       // Core reset, synchronous, high.
  input  wire logic        i_lclk,      // Link byte clock.
  input  wire logic        i_lrst,      // Link reset, sync to i_lclk, high.
  input  wire logic        i_activate,  // Activation pulse, core domain.
  input  wire logic        i_rx_valid,  // Received byte valid, link domain.
  input  wire logic [7:0]  i_rx_data,   // Received byte.
  input  wire logic        i_rx_last,   // Last byte of the frame.
  input  wire logic        i_rx_err,    // Frame broken, valid with last.
  output logic             o_rx_ready,  // Link may hand over a byte.
  output logic             o_tx_valid,  // Byte to send, link domain.
  output logic [7:0]       o_tx_data,   // Byte to send.
  output logic             o_tx_last,   // Last byte of the frame.
  input  wire logic        i_tx_ready,  // Framer takes the byte.
  output logic             o_cmd_valid, // Command APDU byte pulse.
  output logic [7:0]       o_cmd_data,  // Command APDU byte.
  output logic             o_cmd_end,   // Command APDU complete pulse.
  output logic             o_cmd_abort, // Command APDU discarded pulse.
  input  wire logic        i_rsp_valid, // Response data byte valid.
  input  wire logic [7:0]  i_rsp_data,  // Response data byte.
  output logic             o_rsp_ready, // Response byte accepted.
  input  wire logic        i_rsp_done,  // Response data finished.
  input  wire logic [15:0] i_rsp_sw,    // Status word, valid with done.
  output logic             o_active,    // Tag activated, not deselected.
  output logic             o_block_num  // Current tag block number.
);
  localparam int LW = $clog2(RSP_MAX + 1);
  localparam int AW = $clog2(RSP_MAX);
  localparam logic [LW-1:0] CH  = LW'(CHUNK);
  localparam logic [LW-1:0] LIM = LW'(RSP_MAX - cbp_pkg::SW_BYTES);
  localparam logic [LW-1:0] HDR = LW'(cbp_pkg::CMD_HDR);

  typedef struct packed {
    logic                rreq;
    logic                ack_m;
    logic                ack_s;
    logic                rx_ready;
    cbp_pkg::cbp_byte_s  rx_hold;
    logic                treq_m;
    logic                treq_s;
    logic                tack;
    logic                tx_valid;
    cbp_pkg::cbp_byte_s  tx_byte;
  } cbp_lnk_s;

  typedef struct packed {
    cbp_pkg::cbp_state_e state;
    logic                bn;
    logic                rx_chain;
    logic                tx_chain;
    logic                last_i;
    logic                desel;
    logic                bad;
    logic                tx_first;
    logic                tx_done;
    logic [7:0]          pcb;
    logic [7:0]          tx_pcb;
    logic [LW-1:0]       cmd_cnt;
    logic [LW-1:0]       wlen;
    logic [LW-1:0]       rsp_len;
    logic [LW-1:0]       chunk_off;
    logic [LW-1:0]       tx_idx;
    logic [LW-1:0]       tx_n;
    logic [15:0]         sw;
    logic                rreq_m;
    logic                rreq_s;
    logic                rack;
    logic                treq;
    logic                tack_m;
    logic                tack_s;
    cbp_pkg::cbp_byte_s  txb;
    logic                cmd_valid;
    logic [7:0]          cmd_data;
    logic                cmd_end;
    logic                cmd_abort;
    logic                rsp_ready;
    logic                active;
  } cbp_core_s;

  cbp_lnk_s   lr;
  cbp_lnk_s   next_lr;
  cbp_core_s  r;
  cbp_core_s  next_r;
  logic [7:0] mem [RSP_MAX];
  logic          mem_we;
  logic [AW-1:0] mem_wa;
  logic [7:0]    mem_wd;
  logic ev_i, ev_chain, ev_nak, ev_same, ev_desel;

  // Queue a one-byte block; chaining state is kept for a later resend.
  function automatic cbp_core_s send_blk(input cbp_core_s s,
                                         input logic [7:0] pcb);
    s.tx_pcb   = pcb;
    s.tx_n     = '0;
    s.tx_first = 1'b1;
    s.tx_done  = 1'b0;
    s.state    = cbp_pkg::ST_TX;
    return s;
  endfunction : send_blk

  // Queue the I-block holding the response chunk that starts at off.
  function automatic cbp_core_s send_i(input cbp_core_s s,
                                       input logic [LW-1:0] off);
    logic [LW-1:0] rem;
    rem         = s.rsp_len - off;
    s.chunk_off = off;
    s.tx_idx    = off;
    s.tx_chain  = rem > CH;
    s           = send_blk(s, cbp_pkg::PCB_I
                  | (s.tx_chain ? cbp_pkg::PCB_MORE : 8'h00)
                  | {7'h00, s.bn});
    s.tx_n      = s.tx_chain ? CH : rem;
    return s;
  endfunction : send_i

  always_comb begin
    next_lr = lr;
    next_lr.ack_m  = r.rack;
    next_lr.ack_s  = lr.ack_m;
    next_lr.treq_m = r.treq;
    next_lr.treq_s = lr.treq_m;
    if (i_rx_valid && lr.rx_ready) begin
      next_lr.rx_hold = '{i_rx_data, i_rx_last, i_rx_err};
      next_lr.rreq    = ~lr.rreq;
    end
    next_lr.rx_ready = next_lr.rreq == next_lr.ack_s;
    if (lr.tx_valid && i_tx_ready) begin
      next_lr.tx_valid = 1'b0;
      next_lr.tack     = lr.treq_s;
    end else if (!lr.tx_valid && lr.treq_s != lr.tack) begin
      next_lr.tx_valid = 1'b1;
      next_lr.tx_byte  = r.txb;
    end
  end

  always_ff @(posedge i_lclk) begin
    if (i_lrst) begin
      lr <= '0;
    end else begin
      lr <= next_lr;
    end
  end

  always_comb begin
    logic                first;
    logic                bad;
    logic                k_i;
    logic                k_r;
    logic                k_s;
    logic                cidnad;
    logic [7:0]          p;
    cbp_pkg::cbp_byte_s  b;
    next_r = r;
    mem_we = 1'b0;
    mem_wa = r.wlen[AW-1:0];
    mem_wd = i_rsp_data;
    ev_i = 1'b0;
    ev_chain = 1'b0;
    ev_nak = 1'b0;
    ev_same = 1'b0;
    ev_desel = 1'b0;
    next_r.rreq_m = lr.rreq;
    next_r.rreq_s = r.rreq_m;
    next_r.tack_m = lr.tack;
    next_r.tack_s = r.tack_m;
    next_r.cmd_valid = 1'b0;
    next_r.cmd_end   = 1'b0;
    next_r.cmd_abort = 1'b0;
    b      = lr.rx_hold;
    first  = r.state == cbp_pkg::ST_RXW;
    p      = first ? b.data : r.pcb;
    k_i    = (p & cbp_pkg::PCB_I_MASK) == cbp_pkg::PCB_I;
    k_r    = (p & cbp_pkg::PCB_R_MASK) == cbp_pkg::PCB_R;
    k_s    = (p & cbp_pkg::PCB_S_MASK) == cbp_pkg::PCB_S_DSL;
    cidnad = p[cbp_pkg::BIT_CID] | (k_i & p[cbp_pkg::BIT_NAD]);
    bad    = (!first & r.bad) | cidnad | !(k_i | k_r | k_s) | b.err
           | (!first & !k_i);
    // Bytes are always taken so the link never hangs outside a receive.
    if (r.rreq_s != r.rack) begin
      next_r.rack = r.rreq_s;
      if (first || r.state == cbp_pkg::ST_RXB) begin
        next_r.pcb   = p;
        next_r.bad   = bad;
        next_r.state = cbp_pkg::ST_RXB;
        if (!first && k_i && !bad) begin
          next_r.cmd_valid = 1'b1;
          next_r.cmd_data  = b.data;
          next_r.cmd_cnt   = r.cmd_cnt + 1'b1;
        end
        if (b.last) begin
          if (bad || (k_i && !p[cbp_pkg::BIT_MORE]
                      && next_r.cmd_cnt < HDR)) begin
            next_r.cmd_abort = k_i;
            next_r.cmd_cnt   = '0;
            if (r.rx_chain || r.tx_chain) begin
              next_r.state = cbp_pkg::ST_RXW;
            end else begin
              next_r = send_blk(next_r, cbp_pkg::PCB_R
                       | cbp_pkg::PCB_MORE | {7'h00, r.bn});
            end
          end else if (k_i) begin
            ev_i = 1'b1;
            next_r.bn       = ~r.bn;
            next_r.tx_chain = 1'b0;
            next_r.last_i   = 1'b0;
            if (p[cbp_pkg::BIT_MORE]) begin
              ev_chain = 1'b1;
              next_r.rx_chain = 1'b1;
              next_r = send_blk(next_r, cbp_pkg::PCB_R
                       | {7'h00, next_r.bn});
            end else begin
              next_r.rx_chain = 1'b0;
              next_r.cmd_end  = 1'b1;
              next_r.cmd_cnt  = '0;
              next_r.wlen     = '0;
              next_r.state    = cbp_pkg::ST_APP;
            end
          end else if (k_r) begin
            ev_same = p[cbp_pkg::BIT_BN] == r.bn;
            ev_nak  = p[cbp_pkg::BIT_MORE];
            if (ev_same) begin
              next_r = r.last_i ? send_i(next_r, r.chunk_off)
                     : send_blk(next_r, cbp_pkg::PCB_R | {7'h00, r.bn});
            end else if (ev_nak) begin
              next_r = send_blk(next_r, cbp_pkg::PCB_R
                       | {7'h00, r.bn});
            end else begin
              next_r.bn = ~r.bn;
              next_r = r.tx_chain ? send_i(next_r, r.chunk_off + CH)
                     : send_blk(next_r, cbp_pkg::PCB_R
                       | {7'h00, next_r.bn});
            end
          end else begin
            ev_desel = 1'b1;
            next_r.desel = 1'b1;
            next_r = send_blk(next_r, cbp_pkg::PCB_S_DSL);
          end
        end
      end
    end
    unique case (r.state)
      cbp_pkg::ST_APP: begin
        if (i_rsp_valid && r.rsp_ready) begin
          mem_we      = 1'b1;
          next_r.wlen = r.wlen + 1'b1;
        end
        if (i_rsp_done) begin
          next_r.sw    = i_rsp_sw;
          next_r.state = cbp_pkg::ST_SW1;
        end
      end
      cbp_pkg::ST_SW1: begin
        mem_we       = 1'b1;
        mem_wd       = r.sw[15:8];
        next_r.wlen  = r.wlen + 1'b1;
        next_r.state = cbp_pkg::ST_SW2;
      end
      cbp_pkg::ST_SW2: begin
        mem_we         = 1'b1;
        mem_wd         = r.sw[7:0];
        next_r.rsp_len = r.wlen + 1'b1;
        next_r.last_i  = 1'b1;
        next_r         = send_i(next_r, '0);
      end
      cbp_pkg::ST_TX: begin
        // The tag only transmits here, as the answer to a received block.
        if (r.treq == r.tack_s) begin
          if (r.tx_done) begin
            next_r.state = r.desel ? cbp_pkg::ST_OFF : cbp_pkg::ST_RXW;
          end else if (r.tx_first) begin
            next_r.treq     = ~r.treq;
            next_r.txb      = '{r.tx_pcb, r.tx_n == '0, 1'b0};
            next_r.tx_first = 1'b0;
            next_r.tx_done  = r.tx_n == '0;
          end else begin
            next_r.treq    = ~r.treq;
            next_r.txb     = '{mem[r.tx_idx[AW-1:0]], r.tx_n == LW'(1), 1'b0};
            next_r.tx_idx  = r.tx_idx + 1'b1;
            next_r.tx_n    = r.tx_n - 1'b1;
            next_r.tx_done = r.tx_n == LW'(1);
          end
        end
      end
      default: begin
      end
    endcase
    if (i_activate) begin
      next_r.state    = cbp_pkg::ST_RXW;
      next_r.bn       = cbp_pkg::BN_INIT;
      next_r.rx_chain = 1'b0;
      next_r.tx_chain = 1'b0;
      next_r.last_i   = 1'b0;
      next_r.desel    = 1'b0;
      next_r.cmd_cnt  = '0;
    end
    next_r.rsp_ready = next_r.state == cbp_pkg::ST_APP && next_r.wlen < LIM;
    next_r.active    = next_r.state != cbp_pkg::ST_OFF;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      r       <= '0;
      r.state <= cbp_pkg::ST_OFF;
      r.bn    <= cbp_pkg::BN_INIT;
    end else begin
      r <= next_r;
    end
  end

  // The store is written only while collecting, never while a block drains.
  always_ff @(posedge i_clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  assign o_rx_ready  = lr.rx_ready;
  assign o_tx_valid  = lr.tx_valid;
  assign o_tx_data   = lr.tx_byte.data;
  assign o_tx_last   = lr.tx_byte.last;
  assign o_cmd_valid = r.cmd_valid;
  assign o_cmd_data  = r.cmd_data;
  assign o_cmd_end   = r.cmd_end;
  assign o_cmd_abort = r.cmd_abort;
  assign o_rsp_ready = r.rsp_ready;
  assign o_active    = r.active;
  assign o_block_num = r.bn;

  a_act_bn: assert property (@(posedge i_clk) disable iff (i_rst)
    i_activate |=> o_block_num == cbp_pkg::BN_INIT && o_active)
    else $error("block number not one after activation");
  a_i_toggle: assert property (@(posedge i_clk) disable iff (i_rst)
    ev_i && !i_activate |=> r.bn != $past(r.bn))
    else $error("block number not toggled on I-block");
  a_nak_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    ev_nak && !i_activate |=> r.bn == $past(r.bn))
    else $error("block number changed on R(NAK)");
  a_chain_ack: assert property (@(posedge i_clk) disable iff (i_rst)
    ev_chain && !i_activate |=> r.state == cbp_pkg::ST_TX
      && r.tx_pcb == (cbp_pkg::PCB_R | {7'h00, r.bn}))
    else $error("chained I-block not acknowledged");
  a_desel_ans: assert property (@(posedge i_clk) disable iff (i_rst)
    ev_desel && !i_activate |=> r.tx_pcb == cbp_pkg::PCB_S_DSL)
    else $error("deselect not answered");
  a_resend_i: assert property (@(posedge i_clk) disable iff (i_rst)
    ev_same && r.last_i && !i_activate |=> r.tx_idx == $past(r.chunk_off)
      && (r.tx_pcb & cbp_pkg::PCB_I_MASK) == cbp_pkg::PCB_I)
    else $error("last I-block not resent");
  a_nak_ack: assert property (@(posedge i_clk) disable iff (i_rst)
    ev_nak && !ev_same && !i_activate |=>
      r.tx_pcb == (cbp_pkg::PCB_R | {7'h00, r.bn}))
    else $error("differing R(NAK) not answered by R(ACK)");
  a_no_wtx: assert property (@(posedge i_clk) disable iff (i_rst)
    r.state == cbp_pkg::ST_TX |-> r.tx_pcb != cbp_pkg::PCB_S_WTX)
    else $error("wait-time extension queued");
  a_sw_order: assert property (@(posedge i_clk) disable iff (i_rst)
    r.state == cbp_pkg::ST_SW1 && !i_activate |=> r.state == cbp_pkg::ST_SW2)
    else $error("status bytes out of order");
  a_rx_take: assert property (@(posedge i_lclk) disable iff (i_lrst)
    i_rx_valid && o_rx_ready |=> !o_rx_ready)
    else $error("receive handshake not closed");
endmodule : cbp_ctrl

// file: core/cbp_pkg.sv
// Package: constants, state codes and carriers for the block protocol core.
package cbp_pkg;
  localparam logic [7:0] PCB_I      = 8'h02;
  localparam logic [7:0] PCB_I_MASK = 8'he2;
  localparam logic [7:0] PCB_R      = 8'ha2;
  localparam logic [7:0] PCB_R_MASK = 8'he6;
  localparam logic [7:0] PCB_S_DSL  = 8'hc2;
  localparam logic [7:0] PCB_S_MASK = 8'hf7;
  localparam logic [7:0] PCB_S_WTX  = 8'hf2;
  localparam logic [7:0] PCB_MORE   = 8'h10;
  localparam int         BIT_MORE   = 4;
  localparam int         BIT_CID    = 3;
  localparam int         BIT_NAD    = 2;
  localparam int         BIT_BN     = 0;
  localparam logic       BN_INIT    = 1'b1;
  localparam int         RSP_MAX    = 256;
  localparam int         CHUNK      = 64;
  localparam int         CMD_HDR    = 4;
  localparam int         SW_BYTES   = 2;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
    logic       err;
  } cbp_byte_s;

  typedef enum logic [6:0] {
    ST_OFF = 7'h01,
    ST_RXW = 7'h02,
    ST_RXB = 7'h04,
    ST_APP = 7'h08,
    ST_SW1 = 7'h10,
    ST_SW2 = 7'h20,
    ST_TX  = 7'h40
  } cbp_state_e;
endpackage : cbp_pkg

// file: dv/cbp_reader_model.sv
// Reader/writer model that drives the tag's link side in the link clock domain.
`timescale 1ns/1ps
module cbp_reader_model (
  input  wire logic       i_lclk,     // Link byte clock.
  output logic            o_valid,    // Byte offered to the tag.
  output logic [7:0]      o_data,     // Offered byte.
  output logic            o_last,     // Final byte of the frame.
  output logic            o_err,      // Frame marked broken.
  input  wire logic       i_ready,    // Tag takes the byte.
  input  wire logic       i_tx_valid, // Tag byte valid.
  input  wire logic [7:0] i_tx_data,  // Tag byte.
  input  wire logic       i_tx_last,  // Tag frame end.
  output logic            o_tx_ready  // Model takes a tag byte.
);
  typedef logic [7:0] cbp_bytes_t[$];
  logic       bn;
  logic       slow;
  logic [8:0] got[$];

  initial begin
    o_valid = 1'b0;
    o_data = 8'h00;
    o_last = 1'b0;
    o_err = 1'b0;
    o_tx_ready = 1'b1;
    bn = 1'b0;
    slow = 1'b0;
  end

  // A slow reader takes a tag byte only on every other edge.
  always @(posedge i_lclk) begin
    o_tx_ready <= slow ? ~o_tx_ready : 1'b1;
    if (i_tx_valid === 1'b1 && o_tx_ready) begin
      got.push_back({i_tx_last, i_tx_data});
    end
  end

  task automatic activate();
    bn = 1'b0;
  endtask : activate

  // The reader always speaks first; the tag only answers.
  // A turnaround gap comes first, since the tag drops bytes while it sends.
  task automatic send_frame(input cbp_bytes_t q, input logic err);
    repeat (16) @(posedge i_lclk);
    for (int i = 0; i < q.size(); i++) begin
      @(posedge i_lclk);
      o_valid <= 1'b1;
      o_data <= q[i];
      o_last <= (i == q.size() - 1);
      o_err <= err && (i == q.size() - 1);
      do @(posedge i_lclk); while (i_ready !== 1'b1);
      o_valid <= 1'b0;
      o_data <= ~q[i];
      o_last <= 1'b0;
      o_err <= 1'b0;
    end
  endtask : send_frame

  // A missing reply comes back short, so the caller's comparison catches it.
  task automatic get_frame(output cbp_bytes_t q);
    logic [8:0] b;
    q = {};
    for (int n = 0; n < 4000; n++) begin
      if (got.size() > 0 && got[got.size() - 1][8]) break;
      @(posedge i_lclk);
    end
    while (got.size() > 0) begin
      b = got.pop_front();
      q.push_back(b[7:0]);
    end
    if (q.size() > 0 && (q[0] & 8'he2) == 8'h02 && q[0][0] == bn)
      bn = ~bn;
    if (q.size() > 0 && q[0] == {7'h51, bn}) bn = ~bn;
  endtask : get_frame
endmodule : cbp_reader_model

// file: dv/contactless_block_protocol_ctrl_test.sv
// Self-checking bench for the tag block protocol controller.
`timescale 1ns/1ps
module contactless_block_protocol_ctrl_test;
  typedef logic [7:0] cbp_bytes_t[$];
  logic        i_clk, i_rst, i_lclk, i_lrst, i_activate;
  logic        rx_valid, rx_last, rx_err, rx_ready;
  logic        tx_valid, tx_last, tx_ready;
  logic [7:0]  rx_data, tx_data, cmd_data, i_rsp_data;
  logic        cmd_valid, cmd_end, i_rsp_valid, rsp_ready, i_rsp_done;
  logic        cmd_abort;
  logic        active, block_num;
  logic [15:0] i_rsp_sw;
  int          fails, compares, ends, aborts;
  cbp_bytes_t  cmdq, fr;

  cbp_ctrl #(.RSP_MAX(16), .CHUNK(4)) u_cbp_ctrl (
    .i_clk(i_clk), .i_rst(i_rst), .i_lclk(i_lclk), .i_lrst(i_lrst),
    .i_activate(i_activate), .i_rx_valid(rx_valid), .i_rx_data(rx_data),
    .i_rx_last(rx_last), .i_rx_err(rx_err), .o_rx_ready(rx_ready),
    .o_tx_valid(tx_valid), .o_tx_data(tx_data), .o_tx_last(tx_last),
    .i_tx_ready(tx_ready), .o_cmd_valid(cmd_valid), .o_cmd_data(cmd_data),
    .o_cmd_end(cmd_end), .o_cmd_abort(cmd_abort), .i_rsp_valid(i_rsp_valid),
    .i_rsp_data(i_rsp_data), .o_rsp_ready(rsp_ready),
    .i_rsp_done(i_rsp_done), .i_rsp_sw(i_rsp_sw), .o_active(active),
    .o_block_num(block_num));

  cbp_reader_model u_cbp_reader_model (
    .i_lclk(i_lclk), .o_valid(rx_valid), .o_data(rx_data),
    .o_last(rx_last), .o_err(rx_err), .i_ready(rx_ready),
    .i_tx_valid(tx_valid), .i_tx_data(tx_data), .i_tx_last(tx_last),
    .o_tx_ready(tx_ready));

  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  initial begin
    i_lclk = 1'b0;
    #7;
    forever #6 i_lclk = ~i_lclk;
  end

  always @(posedge i_clk) begin
    if (cmd_valid === 1'b1) cmdq.push_back(cmd_data);
    if (cmd_end === 1'b1) ends++;
    if (cmd_abort === 1'b1) aborts++;
  end

  task automatic end_of_test();
    if (fails == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  task automatic check_byte(string what, logic [7:0] exp, logic [7:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check_byte

  task automatic check_bytes(string what, cbp_bytes_t exp, cbp_bytes_t got);
    check_byte({what, " length"}, 8'(exp.size()), 8'(got.size()));
    for (int i = 0; i < exp.size() && i < got.size(); i++)
      check_byte(what, exp[i], got[i]);
  endtask : check_bytes

  task automatic xchg(string what, cbp_bytes_t f, logic err, cbp_bytes_t exp);
    u_cbp_reader_model.send_frame(f, err);
    u_cbp_reader_model.get_frame(fr);
    check_bytes(what, exp, fr);
  endtask : xchg

  // Sends an I-block, waits for the APDU end and plays the application.
  task automatic apdu(cbp_bytes_t f, cbp_bytes_t d, logic [15:0] sw);
    int n0;
    n0 = ends;
    u_cbp_reader_model.send_frame(f, 1'b0);
    for (int k = 0; k < 2000 && ends == n0; k++) @(posedge i_clk);
    check_byte("command end count", 8'h01, 8'(ends - n0));
    foreach (d[i]) begin
      @(posedge i_clk);
      i_rsp_valid <= 1'b1;
      i_rsp_data <= d[i];
      do @(posedge i_clk); while (rsp_ready !== 1'b1);
      i_rsp_valid <= 1'b0;
      i_rsp_data <= ~d[i];
    end
    @(posedge i_clk);
    i_rsp_done <= 1'b1;
    i_rsp_sw <= sw;
    @(posedge i_clk);
    i_rsp_done <= 1'b0;
    i_rsp_sw <= ~sw;
  endtask : apdu

  task automatic test_activate();
    check_byte("reset block number", 8'h01, {7'h00, block_num});
    @(posedge i_clk);
    i_activate <= 1'b1;
    @(posedge i_clk);
    i_activate <= 1'b0;
    u_cbp_reader_model.activate();
    repeat (2) @(posedge i_clk);
    check_byte("active", 8'h01, {7'h00, active});
    check_byte("block number", 8'h01, {7'h00, block_num});
  endtask : test_activate

  task automatic test_plain();
    cmdq = {};
    apdu('{8'h02, 8'h00, 8'hb0, 8'h00, 8'h00, 8'h01}, '{8'haa}, 16'h9000);
    check_bytes("command", '{8'h00, 8'hb0, 8'h00, 8'h00, 8'h01}, cmdq);
    u_cbp_reader_model.get_frame(fr);
    check_bytes("reply", '{8'h02, 8'haa, 8'h90, 8'h00}, fr);
    xchg("nak same", '{8'hb2}, 1'b0, '{8'h02, 8'haa, 8'h90, 8'h00});
    xchg("nak other", '{8'hb3}, 1'b0, '{8'ha2});
    check_byte("block number", 8'h00, {7'h00, block_num});
  endtask : test_plain

  task automatic test_invalid();
    int n0;
    n0 = aborts;
    xchg("broken", '{8'h03, 8'h00, 8'hb0, 8'h00, 8'h00}, 1'b1, '{8'hb2});
    xchg("card id", '{8'h0b, 8'h00, 8'h00, 8'h00, 8'h00}, 1'b0, '{8'hb2});
    xchg("wait ext", '{8'hf2, 8'h01}, 1'b0, '{8'hb2});
    xchg("short", '{8'h03, 8'h00, 8'ha4}, 1'b0, '{8'hb2});
    check_byte("block number", 8'h00, {7'h00, block_num});
    check_byte("abort count", 8'h03, 8'(aborts - n0));
  endtask : test_invalid

  task automatic test_chain();
    cbp_bytes_t none;
    u_cbp_reader_model.slow = 1'b1;
    cmdq = {};
    xchg("chain ack", '{8'h13, 8'h00, 8'hd6, 8'h00}, 1'b0, '{8'ha3});
    apdu('{8'h02, 8'h00, 8'h01, 8'haa}, '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55},
         16'h9000);
    check_bytes("chained command", '{8'h00, 8'hd6, 8'h00, 8'h00, 8'h01,
                8'haa}, cmdq);
    u_cbp_reader_model.get_frame(fr);
    check_bytes("chunk one", '{8'h12, 8'h11, 8'h22, 8'h33, 8'h44}, fr);
    xchg("chain error", '{8'ha3}, 1'b1, none);
    xchg("chunk two", '{8'ha3}, 1'b0, '{8'h03, 8'h55, 8'h90, 8'h00});
    check_byte("block number", 8'h01, {7'h00, block_num});
    u_cbp_reader_model.slow = 1'b0;
  endtask : test_chain

  task automatic test_deselect();
    xchg("deselect", '{8'hc2}, 1'b0, '{8'hc2});
    repeat (4) @(posedge i_clk);
    check_byte("active after deselect", 8'h00, {7'h00, active});
  endtask : test_deselect

  initial begin
    i_rst = 1'b1;
    i_lrst = 1'b1;
    i_activate = 1'b0;
    i_rsp_valid = 1'b0;
    i_rsp_data = 8'h00;
    i_rsp_done = 1'b0;
    i_rsp_sw = 16'h0000;
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_lclk);
    i_lrst <= 1'b0;
    repeat (4) @(posedge i_clk);
    test_activate();
    test_plain();
    test_invalid();
    test_chain();
    test_deselect();
    end_of_test();
  end

  // About twenty short frames need well under a tenth of this span.
  initial begin
    #1000000;
    fails++;
    end_of_test();
  end
endmodule : contactless_block_protocol_ctrl_test
